/* File: rtl/tocr_pkg.sv */
// tocr_pkg: offsets, field positions, reset values and timing for the timer control block
// assumes a 32-bit apb slave with one register per aligned word
package tocr_pkg;
   // register byte offsets
   localparam logic [11:0] CTRL_OFF   = 12'h000; // timer_one_control
   localparam logic [11:0] COUNT_OFF  = 12'h004; // counter_high_byte:counter_low_byte
   localparam logic [11:0] STATUS_OFF = 12'h008; // run state, osc state, synced pins
   localparam logic [11:0] CLKMODE_OFF = 12'h00c; // system clock mode flag
   // control field positions
   localparam int GATE_INV_BIT  = 7;
   localparam int GATE_EN_BIT   = 6;
   localparam int PRESC_HI_BIT  = 5;
   localparam int PRESC_LO_BIT  = 4;
   localparam int OSC_EN_BIT    = 3;
   localparam int UNSYNC_BIT    = 2;
   localparam int CLK_SRC_BIT   = 1;
   localparam int TIMER_ON_BIT  = 0;
   // reset values
   localparam logic [7:0]  CTRL_RST    = 8'h00;
   localparam logic [15:0] COUNT_RST   = 16'h0000;
   localparam logic [0:0]  CLKMODE_RST = 1'h0;
   // instruction cycle: four system clocks
   localparam int INSTR_CYCLE_NS  = 20;
   localparam int CLK_PERIOD_NS   = 5;
   localparam int INSTR_CYCLE_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage

/* File: rtl/tocr_timer.sv */
// tocr_timer: timer control register, prescaler and 16-bit counter behind an apb slave
// assumes pclk at 200 MHz, gate and external clock pins asynchronous to pclk
//
// How it works
// - 8-bit read/write control register, all zero at reset, fields bit7 down to bit0.
// - polarity bit 1 counts while gate high, 0 counts while gate low.
// - gate enable ignored when off; when on, 1 gates counting, 0 runs freely.
// - prescale codes 00,01,10,11 divide input clock by 1,2,4,8.
// - oscillator enable works only in internal oscillator mode, otherwise oscillator off.
// - external source: unsync bit 1 skips the agreement filter, 0 uses it; internal ignores it.
// - internal source counts once per instruction cycle times prescale ratio.
`timescale 1ns/1ps
`default_nettype none
module tocr_timer (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        gate_input_pin,
   input  wire logic        external_clock_pin,
   output logic             low_power_osc_on,
   output logic [15:0]      count_value
);
   logic [7:0]  ctrl_r;
   logic        clkmode_r;      // 1: internal_rc_oscillator without clock output
   logic [15:0] count_r;
   logic [2:0]  presc_r;
   logic [1:0]  icyc_r;
   logic [2:0]  gate_sy_r;
   logic [2:0]  ext_sy_r;
   logic        gate_st_r;
   logic        ext_st_r;
   logic        ext_prev_r;
   // control fields by name, decoded once from the register
   logic        gate_inv;
   logic        gate_en;
   logic [1:0]  presc_sel;
   logic        osc_en;
   logic        ext_unsync;
   logic        clk_src;
   logic        timer_on;
   logic        osc_r;
   logic        running;
   logic        tick;
   logic        in_edge;
   logic        presc_done;
   logic        wr_acc;
   logic        rd_acc;

   // apb access phase, zero wait states
   assign wr_acc = psel && penable && pwrite && clk_en;
   assign rd_acc = psel && penable && !pwrite && clk_en;

   // named control fields for the run, edge and oscillator logic
   assign gate_inv   = ctrl_r[tocr_pkg::GATE_INV_BIT];
   assign gate_en    = ctrl_r[tocr_pkg::GATE_EN_BIT];
   assign presc_sel  = ctrl_r[tocr_pkg::PRESC_HI_BIT:tocr_pkg::PRESC_LO_BIT];
   assign osc_en     = ctrl_r[tocr_pkg::OSC_EN_BIT];
   assign ext_unsync = ctrl_r[tocr_pkg::UNSYNC_BIT];
   assign clk_src    = ctrl_r[tocr_pkg::CLK_SRC_BIT];
   assign timer_on   = ctrl_r[tocr_pkg::TIMER_ON_BIT];

   // the instruction cycle divider is two bits wide
   // a longer cycle would silently wrap and count too fast
   if (tocr_pkg::INSTR_CYCLE_CLKS < 1 || tocr_pkg::INSTR_CYCLE_CLKS > 4) begin : g_icyc_check
      $error("instruction cycle length does not fit the divider");
   end

   // divide ratio minus one for a prescale code
   function automatic logic [2:0] presc_max(input logic [1:0] code);
      unique case (code)
         2'h0: presc_max = 3'h0;
         2'h1: presc_max = 3'h1;
         2'h2: presc_max = 3'h3;
         default: presc_max = 3'h7;
      endcase
   endfunction

   // control and clock mode registers
   // the clock mode flag stands in for the system clock configuration,
   // which lives outside this block
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r    <= tocr_pkg::CTRL_RST;
         clkmode_r <= tocr_pkg::CLKMODE_RST[0];
      end else if (wr_acc && paddr == tocr_pkg::CTRL_OFF) begin
         ctrl_r <= pwdata[7:0];
      end else if (wr_acc && paddr == tocr_pkg::CLKMODE_OFF) begin
         clkmode_r <= pwdata[0];
      end
   end

   // pin synchronisers: three stages, change when stages two and three agree
   // only the second stage reads the first, so metastability stays contained
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_sy_r  <= 3'h0;
         ext_sy_r   <= 3'h0;
         gate_st_r  <= 1'b0;
         ext_st_r   <= 1'b0;
      end else if (clk_en) begin
         gate_sy_r <= {gate_sy_r[1:0], gate_input_pin};
         ext_sy_r  <= {ext_sy_r[1:0], external_clock_pin};
         if (gate_sy_r[1] == gate_sy_r[2]) begin
            gate_st_r <= gate_sy_r[2];
         end
         if (ext_sy_r[1] == ext_sy_r[2]) begin
            ext_st_r <= ext_sy_r[2];
         end
      end
   end

   // gate qualification and run decision
   always_comb begin
      logic gate_active;
      // polarity picks which gate level lets the timer count
      gate_active = gate_inv ? gate_st_r : !gate_st_r;
      // gate enable only matters while the timer is on
      running = timer_on && (!gate_en || gate_active);
   end

   // input edge: instruction cycle or external rising edge
   always_comb begin
      if (clk_src) begin
         // unsync mode takes the edge straight from stages two and three, no agreement filter,
         // so it reacts two cycles sooner but passes a glitch that spans a single sample
         if (ext_unsync) begin
            in_edge = ext_sy_r[1] && !ext_sy_r[2];
         end else begin
            in_edge = ext_st_r && !ext_prev_r;
         end
      end else begin
         in_edge = (icyc_r == 2'(tocr_pkg::INSTR_CYCLE_CLKS - 1));
      end
   end

   // instruction cycle divider, free running
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         icyc_r     <= 2'h0;
         ext_prev_r <= 1'b0;
      end else if (clk_en) begin
         icyc_r     <= (icyc_r == 2'(tocr_pkg::INSTR_CYCLE_CLKS - 1)) ? 2'h0 : icyc_r + 2'h1;
         ext_prev_r <= ext_st_r;
      end
   end

   // greater-or-equal: a ratio lowered mid-count must not wrap through eight
   assign presc_done = (presc_r >= presc_max(presc_sel));
   assign tick = running && in_edge && presc_done;

   // prescaler: cleared by a counter write, frozen while stopped
   // it is not readable, so software only sees its effect on the rate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         presc_r <= 3'h0;
      end else if (clk_en) begin
         if (wr_acc && paddr == tocr_pkg::COUNT_OFF) begin
            presc_r <= 3'h0;
         end else if (running && in_edge) begin
            presc_r <= presc_done ? 3'h0 : presc_r + 3'h1;
         end
      end
   end

   // counter: write wins over increment, holds while stopped
   // software should stop the timer before writing to avoid a lost tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= tocr_pkg::COUNT_RST;
      end else if (clk_en) begin
         if (wr_acc && paddr == tocr_pkg::COUNT_OFF) begin
            count_r <= pwdata[15:0];
         end else if (tick) begin
            count_r <= count_r + 16'h0001;
         end
      end
   end

   // low-power oscillator enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_r <= 1'b0;
      end else if (clk_en) begin
         osc_r <= clkmode_r && osc_en;
      end
   end

   // apb read data, captured in the setup cycle
   // the word then stands through the access phase and until the next read
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
      end else if (psel && !penable && !pwrite && clk_en) begin
         unique case (paddr)
            tocr_pkg::CTRL_OFF:    prdata <= {24'h0, ctrl_r};
            tocr_pkg::COUNT_OFF:   prdata <= {16'h0, count_r};
            tocr_pkg::STATUS_OFF:  prdata <= {28'h0, ext_st_r, gate_st_r, osc_r, running};
            tocr_pkg::CLKMODE_OFF: prdata <= {31'h0, clkmode_r};
            default:               prdata <= 32'h0;
         endcase
      end
   end

   // bus answer: ready from the first edge after reset, never an error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else if (clk_en) begin
         pready  <= 1'b1;
         pslverr <= 1'b0;
      end
   end

   assign low_power_osc_on = osc_r;
   assign count_value = count_r;

   // assertions
   a_ctrl_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == tocr_pkg::CTRL_OFF) |=> ctrl_r == $past(pwdata[7:0]))
      else $error("control write not stored");
   a_off_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !ctrl_r[0] && !(wr_acc && paddr == tocr_pkg::COUNT_OFF)) |=> $stable(count_r))
      else $error("counter moved while off");
   a_gate_pol: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[0] && ctrl_r[6] && (gate_st_r != ctrl_r[7])) |-> !running)
      else $error("counted with gate inactive");
   a_gate_free: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[0] && !ctrl_r[6]) |-> running)
      else $error("free run blocked");
   a_presc_div: assert property (@(posedge pclk) disable iff (!presetn)
      tick |-> presc_r >= presc_max(presc_sel))
      else $error("prescale ratio wrong");
   a_osc_mode: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !clkmode_r) |=> !low_power_osc_on)
      else $error("oscillator on outside mode");
   a_int_rate: assert property (@(posedge pclk) disable iff (!presetn)
      (tick && !ctrl_r[1]) |-> icyc_r == 2'h3)
      else $error("internal tick off cycle");
   a_sync_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl_r[1] && !ctrl_r[2] && in_edge) |-> (ext_st_r && !ext_prev_r))
      else $error("sync edge wrong");
   c_count: cover property (@(posedge pclk) disable iff (!presetn) tick);
   c_gated: cover property (@(posedge pclk) disable iff (!presetn) ctrl_r[0] && ctrl_r[6] && running);
   c_ext: cover property (@(posedge pclk) disable iff (!presetn) tick && ctrl_r[1]);
   c_div8: cover property (@(posedge pclk) disable iff (!presetn) tick && ctrl_r[5:4] == 2'h3);
   c_unsync: cover property (@(posedge pclk) disable iff (!presetn) tick && clk_src && ext_unsync);
   // edge source, counter write and increment, prescaler bookkeeping and clock enable freeze
   a_unsync_edge: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_src && ext_unsync && in_edge) |-> (ext_sy_r[1] && !ext_sy_r[2]))
      else $error("unsync edge wrong");
   a_tick_incr: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && tick && !(wr_acc && paddr == tocr_pkg::COUNT_OFF)) |=> count_r == $past(count_r) + 16'h0001)
      else $error("tick did not increment");
   a_presc_clear: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == tocr_pkg::COUNT_OFF) |=> presc_r == 3'h0)
      else $error("prescaler not cleared");
   a_presc_hold: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && !running && !(wr_acc && paddr == tocr_pkg::COUNT_OFF)) |=> $stable(presc_r))
      else $error("prescaler moved while stopped");
   a_count_write: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == tocr_pkg::COUNT_OFF) |=> count_r == $past(pwdata[15:0]))
      else $error("counter write not stored");
   a_clken_freeze: assert property (@(posedge pclk) disable iff (!presetn)
      !clk_en |=> ($stable(count_r) && $stable(ctrl_r)))
      else $error("state moved while frozen");
   // run decision, oscillator and read path
   a_run_off: assert property (@(posedge pclk) disable iff (!presetn)
      !timer_on |-> !running)
      else $error("running while off");
   a_gate_open: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_on && gate_en && (gate_st_r == gate_inv)) |-> running)
      else $error("gate active but stopped");
   a_osc_on: assert property (@(posedge pclk) disable iff (!presetn)
      (clk_en && clkmode_r && osc_en) |=> low_power_osc_on)
      else $error("oscillator not enabled");
   a_rd_ctrl: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && clk_en && paddr == tocr_pkg::CTRL_OFF) |=> prdata == {24'h0, $past(ctrl_r)})
      else $error("control read wrong");
   a_rd_hold: assert property (@(posedge pclk) disable iff (!presetn)
      rd_acc |=> $stable(prdata))
      else $error("read data moved");
endmodule
`default_nettype wire

/* File: bench/tocr_timer_test.sv */
// tocr_timer_test: apb register, prescale, gate, clock source and oscillator checks
// assumes tocr_pkg and tocr_timer compiled first; pclk 200 MHz
`timescale 1ns/1ps
`default_nettype none
module tocr_timer_test;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        clk_en = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        perr;
   logic        gate = 1'b0;
   logic        ext = 1'b0;
   logic        osc;
   logic [15:0] cnt;
   logic [31:0] q;
   logic [15:0] c0;
   int          mismatches = 0;
   int          cmp_count = 0;
   int          cycles = 0;
   logic [7:0]  ctl_t[11] = '{8'h01, 8'h11, 8'h21, 8'h31, 8'h00, 8'h41, 8'h41, 8'hc1, 8'hc1, 8'h81, 8'h40};
   logic        gate_t[11] = '{0, 0, 0, 0, 0, 1, 0, 0, 1, 0, 0};
   int          exp_t[11] = '{100, 50, 25, 12, 0, 0, 100, 0, 100, 100, 0};
   tocr_timer u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(perr),
      .gate_input_pin(gate), .external_clock_pin(ext), .low_power_osc_on(osc), .count_value(cnt));
   // clock and hang guard
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         report_and_stop();
      end
   end
   // one apb transfer, held until pready is sampled high
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // count increments over 400 cycles, one off allowed for phase
   task automatic rate(input int exp);
      int d;
      repeat (8) @(posedge pclk);
      c0 = cnt;
      repeat (400) @(posedge pclk);
      d = int'(cnt - c0);
      check({31'h0, exp == 0 ? d == 0 : (d + 1 >= exp && d <= exp + 1)}, 32'h1);
   endtask
   // twenty slow pulses on the external clock pin
   task automatic pulses(input logic [7:0] c);
      apb(1'b1, tocr_pkg::CTRL_OFF, {24'h0, c});
      repeat (8) @(posedge pclk);
      c0 = cnt;
      repeat (20) begin
         ext <= 1'b1;
         repeat (8) @(posedge pclk);
         ext <= 1'b0;
         repeat (8) @(posedge pclk);
      end
      repeat (8) @(posedge pclk);
      check({16'h0, cnt - c0}, 32'h14);
   endtask
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
      if (mismatches == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence
   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, tocr_pkg::CTRL_OFF, 32'h0);
      check(q, 32'h0);
      apb(1'b1, tocr_pkg::CTRL_OFF, 32'hffff_ffa5);
      apb(1'b0, tocr_pkg::CTRL_OFF, 32'h0);
      check(q, 32'h0000_00a5);
      apb(1'b1, 12'h010, 32'h0000_00ff);
      apb(1'b0, 12'h010, 32'h0);
      check(q, 32'h0);
      check({31'h0, perr}, 32'h0);
      apb(1'b0, tocr_pkg::CTRL_OFF, 32'h0);
      check(q, 32'h0000_00a5);
      apb(1'b1, tocr_pkg::CTRL_OFF, 32'h0000_005a);
      apb(1'b0, tocr_pkg::CTRL_OFF, 32'h0);
      check(q, 32'h0000_005a);
      apb(1'b1, tocr_pkg::CTRL_OFF, 32'h0);
      apb(1'b1, tocr_pkg::COUNT_OFF, 32'h0000_1234);
      apb(1'b0, tocr_pkg::COUNT_OFF, 32'h0);
      check(q, 32'h0000_1234);
      // prescale, off, gate polarity and gate enable table
      for (int i = 0; i < 11; i++) begin
         gate <= gate_t[i];
         apb(1'b1, tocr_pkg::CTRL_OFF, {24'h0, ctl_t[i]});
         rate(exp_t[i]);
      end
      // clock enable low freezes a running count
      apb(1'b1, tocr_pkg::CTRL_OFF, 32'h0000_0001);
      clk_en <= 1'b0;
      repeat (2) @(posedge pclk);
      c0 = cnt;
      repeat (40) @(posedge pclk);
      check({16'h0, cnt - c0}, 32'h0);
      clk_en <= 1'b1;
      pulses(8'h03);
      pulses(8'h07);
      apb(1'b1, tocr_pkg::CTRL_OFF, 32'h0000_0008);
      repeat (8) @(posedge pclk);
      check({31'h0, osc}, 32'h0);
      apb(1'b1, tocr_pkg::CLKMODE_OFF, 32'h1);
      repeat (8) @(posedge pclk);
      check({31'h0, osc}, 32'h1);
      apb(1'b0, tocr_pkg::STATUS_OFF, 32'h0);
      check(q, 32'h0000_0002);
      apb(1'b1, tocr_pkg::CTRL_OFF, 32'h0);
      repeat (8) @(posedge pclk);
      check({31'h0, osc}, 32'h0);
      report_and_stop();
   end
endmodule
`default_nettype wire
